//--- src/scmi_pkg.sv
package scmi_pkg;

  // Bus and flag widths
  localparam int unsigned AXI_ADDR_W = 32;
  localparam int unsigned AXI_DATA_W = 32;
  localparam int unsigned FLAG_W     = 15;
  localparam int unsigned LVL_W      = 3;

  // Register byte addresses
  localparam logic [31:0] OFS_CTRL1_IRQ_PENDING = 32'h4000a808;
  localparam logic [31:0] OFS_CTRL2_IRQ_PENDING = 32'h4000a80c;
  localparam logic [31:0] OFS_CTRL1_IRQ_ENABLE  = 32'h4000a848;
  localparam logic [31:0] OFS_CTRL2_IRQ_ENABLE  = 32'h4000a84c;
  localparam logic [31:0] OFS_CTRL1_TRIG_STYLE  = 32'h4000a854;
  localparam logic [31:0] OFS_CTRL2_TRIG_STYLE  = 32'h4000a858;
  localparam logic [31:0] OFS_CTRL2_MODE_SELECT = 32'h4000c054;
  localparam logic [31:0] OFS_CTRL1_MODE_SELECT = 32'h4000c854;

  // Reset values
  localparam logic [14:0] PENDING_RST = 15'h0000;
  localparam logic [14:0] ENABLE_RST  = 15'h0000;
  localparam logic [2:0]  TRIG_RST    = 3'h0;

  // Source groups by flag position
  localparam logic [14:0] ASYNC_SRC_MASK   = 15'h6000;
  localparam logic [14:0] DMA_SRC_MASK     = 15'h1e00;
  localparam logic [14:0] TWOWIRE_SRC_MASK = 15'h01e0;
  localparam logic [14:0] COMMON_SRC_MASK  = 15'h001f;
  // Second controller has no asynchronous fault flags
  localparam logic [14:0] CTRL2_BIT_MASK   = 15'h1fff;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Controller function field encodings
  typedef enum logic [1:0] {
    MODE_OFF     = 2'h0,
    MODE_ASYNC   = 2'h1,
    MODE_SYNC    = 2'h2,
    MODE_TWOWIRE = 2'h3
  } scmi_mode_t;

  // Pulse events from one engine, flag bits 14 down to 3
  typedef struct packed {
    logic parity_fault_flag;
    logic framing_fault_flag;
    logic dma_tx_buf_b_done;
    logic dma_tx_buf_a_done;
    logic dma_rx_buf_b_done;
    logic dma_rx_buf_a_done;
    logic twowire_no_ack_flag;
    logic bus_condition_done_flag;
    logic twowire_send_done_flag;
    logic twowire_recv_done_flag;
    logic send_underflow_flag;
    logic recv_overflow_flag;
  } scmi_evt_t;

  // Status levels from one engine, flag bits 2 down to 0
  typedef struct packed {
    logic sender_idle_flag;
    logic send_space_flag;
    logic recv_data_flag;
  } scmi_lvl_t;

  // Sources allowed to raise flags in a given mode
  function automatic logic [14:0] scmi_source_mask(scmi_mode_t mode, logic has_async);
    logic [14:0] m;
    m = 15'h0000;
    case (mode)
      MODE_ASYNC:   m = has_async ? (COMMON_SRC_MASK | DMA_SRC_MASK | ASYNC_SRC_MASK)
                                  : 15'h0000;
      MODE_SYNC:    m = COMMON_SRC_MASK | DMA_SRC_MASK;
      MODE_TWOWIRE: m = COMMON_SRC_MASK | TWOWIRE_SRC_MASK;
      default:      m = 15'h0000;
    endcase
    return m;
  endfunction

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] scmi_lane_mask(logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

endpackage

//--- src/scmi_event_gate.sv
`timescale 1ns/100ps
`default_nettype none

module scmi_event_gate #(
  parameter logic HAS_ASYNC = 1'b1  // Controller supports asynchronous mode
) (
  input  wire scmi_pkg::scmi_mode_t mode,
  input  wire scmi_pkg::scmi_evt_t  evt_in,
  input  wire scmi_pkg::scmi_lvl_t  lvl_in,
  output logic [14:0]               gated
);
  import scmi_pkg::*;

  // Engine sources masked by function field
  always_comb begin
    gated = {evt_in, lvl_in} & scmi_source_mask(mode, HAS_ASYNC);
  end

endmodule

`default_nettype wire

//--- src/scmi_flag_bank.sv
`timescale 1ns/100ps
`default_nettype none

module scmi_flag_bank (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [14:0] gated,
  input  wire logic [2:0]  trig_style,
  input  wire logic [14:0] enable,
  input  wire logic [14:0] clear,
  output logic      [14:0] pending,
  output logic             irq
);
  import scmi_pkg::*;

  logic [2:0]  lvl_prev;      // Level sources one cycle ago
  logic [14:0] set_bits;      // Sources raising a flag now
  logic [14:0] next_pending;
  logic [2:0]  next_lvl_prev;
  logic        next_irq;

  // Flag set, clear and interrupt combine
  always_comb begin
    set_bits = gated;
    set_bits[2:0] = gated[2:0] & (trig_style | ~lvl_prev);
    next_pending = (pending & ~clear) | set_bits;
    next_lvl_prev = gated[2:0];
    next_irq = |(pending & enable);
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending  <= PENDING_RST;
      lvl_prev <= 3'h0;
      irq      <= 1'b0;
    end else begin
      pending  <= next_pending;
      lvl_prev <= next_lvl_prev;
      irq      <= next_irq;
    end
  end

endmodule

`default_nettype wire

//--- src/scmi_top.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module scmi_top (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Write address channel
  input  wire logic [31:0]          awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  // Write data channel
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  // Write response channel
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  // Read address channel
  input  wire logic [31:0]          araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  // Read data channel
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // Engine sources, first controller
  input  wire scmi_pkg::scmi_evt_t  evt_one,
  input  wire scmi_pkg::scmi_lvl_t  lvl_one,
  // Engine sources, second controller
  input  wire scmi_pkg::scmi_evt_t  evt_two,
  input  wire scmi_pkg::scmi_lvl_t  lvl_two,
  // Function fields to the engines
  output scmi_pkg::scmi_mode_t      mode_one,
  output scmi_pkg::scmi_mode_t      mode_two,
  // Top-level interrupts
  output logic                      irq_one,
  output logic                      irq_two
);
  import scmi_pkg::*;

  // Write channel holding registers
  logic [31:0] aw_addr;        // Captured write address
  logic [31:0] w_data;         // Captured write data
  logic [3:0]  w_strb;         // Captured byte strobes
  logic [31:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_awready;
  logic        next_wready;
  logic        next_bvalid;
  logic [1:0]  next_bresp;

  // Read channel next values
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  // Software-visible configuration
  logic [14:0] enable_one;     // First controller source enables
  logic [14:0] enable_two;     // Second controller source enables
  logic [2:0]  trig_one;       // First controller trigger styles
  logic [2:0]  trig_two;       // Second controller trigger styles
  scmi_mode_t  next_mode_one;
  scmi_mode_t  next_mode_two;
  logic [14:0] next_enable_one;
  logic [14:0] next_enable_two;
  logic [2:0]  next_trig_one;
  logic [2:0]  next_trig_two;

  // Pending flag clear pulses and state
  logic [14:0] clear_one;
  logic [14:0] clear_two;
  logic [14:0] pending_one;
  logic [14:0] pending_two;
  logic [14:0] gated_one;
  logic [14:0] gated_two;

  // Handshake helpers
  logic        aw_take;        // Address accepted this edge
  logic        w_take;         // Data accepted this edge
  logic        ar_take;        // Read address accepted
  logic        do_write;       // Both halves held, slot free
  logic [31:0] lanes;          // Strobes as a bit mask
  logic [31:0] wbits;          // Strobed write data

  assign aw_take  = awvalid & awready;
  assign w_take   = wvalid & wready;
  assign ar_take  = arvalid & arready;
  // Writes wait for a free response slot
  assign do_write = ~awready & ~wready & ~bvalid;
  assign lanes    = scmi_lane_mask(w_strb);
  assign wbits    = w_data & lanes;

  // Write path: capture, decode and respond
  always_comb begin
    next_aw_addr    = aw_addr;
    next_w_data     = w_data;
    next_w_strb     = w_strb;
    next_awready    = awready;
    next_wready     = wready;
    next_bvalid     = bvalid;
    next_bresp      = bresp;
    next_mode_one   = mode_one;
    next_mode_two   = mode_two;
    next_enable_one = enable_one;
    next_enable_two = enable_two;
    next_trig_one   = trig_one;
    next_trig_two   = trig_two;
    clear_one       = 15'h0000;
    clear_two       = 15'h0000;
    // Address and data arrive in either order
    if (aw_take) begin
      next_aw_addr = awaddr;
      next_awready = 1'b0;
    end
    if (w_take) begin
      next_w_data = wdata;
      next_w_strb = wstrb;
      next_wready = 1'b0;
    end
    // Response retires on its handshake
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_awready = 1'b1;
      next_wready  = 1'b1;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      if (aw_addr == OFS_CTRL1_MODE_SELECT) begin
        if (w_strb[0]) begin
          next_mode_one = scmi_mode_t'(w_data[1:0]);
        end
      end else if (aw_addr == OFS_CTRL2_MODE_SELECT) begin
        if (w_strb[0] && (w_data[1:0] != MODE_ASYNC)) begin
          next_mode_two = scmi_mode_t'(w_data[1:0]);
        end
      end else if (aw_addr == OFS_CTRL1_IRQ_PENDING) begin
        clear_one = wbits[14:0];
      end else if (aw_addr == OFS_CTRL2_IRQ_PENDING) begin
        clear_two = wbits[14:0] & CTRL2_BIT_MASK;
      end else if (aw_addr == OFS_CTRL1_IRQ_ENABLE) begin
        next_enable_one = (enable_one & ~lanes[14:0]) | wbits[14:0];
      end else if (aw_addr == OFS_CTRL2_IRQ_ENABLE) begin
        next_enable_two = ((enable_two & ~lanes[14:0]) | wbits[14:0])
                          & CTRL2_BIT_MASK;
      end else if (aw_addr == OFS_CTRL1_TRIG_STYLE) begin
        next_trig_one = (trig_one & ~lanes[2:0]) | wbits[2:0];
      end else if (aw_addr == OFS_CTRL2_TRIG_STYLE) begin
        next_trig_two = (trig_two & ~lanes[2:0]) | wbits[2:0];
      end else begin
        // Unmapped: error answer, no effect
        next_bresp = RESP_SLVERR;
      end
    end
  end

  // Write path registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr    <= 32'h0000_0000;
      w_data     <= 32'h0000_0000;
      w_strb     <= 4'h0;
      awready    <= 1'b1;
      wready     <= 1'b1;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
      mode_one   <= MODE_OFF;
      mode_two   <= MODE_OFF;
      enable_one <= ENABLE_RST;
      enable_two <= ENABLE_RST;
      trig_one   <= TRIG_RST;
      trig_two   <= TRIG_RST;
    end else begin
      aw_addr    <= next_aw_addr;
      w_data     <= next_w_data;
      w_strb     <= next_w_strb;
      awready    <= next_awready;
      wready     <= next_wready;
      bvalid     <= next_bvalid;
      bresp      <= next_bresp;
      mode_one   <= next_mode_one;
      mode_two   <= next_mode_two;
      enable_one <= next_enable_one;
      enable_two <= next_enable_two;
      trig_one   <= next_trig_one;
      trig_two   <= next_trig_two;
    end
  end

  // Read path: answer one cycle after address
  always_comb begin
    next_arready = arready;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    // Data retires, address slot reopens
    if (rvalid && rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    if (ar_take) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = RESP_OKAY;
      next_rdata   = 32'h0000_0000;
      // Reads have no side effects
      if (araddr == OFS_CTRL1_MODE_SELECT) begin
        next_rdata[1:0] = mode_one;
      end else if (araddr == OFS_CTRL2_MODE_SELECT) begin
        next_rdata[1:0] = mode_two;
      end else if (araddr == OFS_CTRL1_IRQ_PENDING) begin
        next_rdata[14:0] = pending_one;
      end else if (araddr == OFS_CTRL2_IRQ_PENDING) begin
        next_rdata[14:0] = pending_two;
      end else if (araddr == OFS_CTRL1_IRQ_ENABLE) begin
        next_rdata[14:0] = enable_one;
      end else if (araddr == OFS_CTRL2_IRQ_ENABLE) begin
        next_rdata[14:0] = enable_two;
      end else if (araddr == OFS_CTRL1_TRIG_STYLE) begin
        next_rdata[2:0] = trig_one;
      end else if (araddr == OFS_CTRL2_TRIG_STYLE) begin
        next_rdata[2:0] = trig_two;
      end else begin
        // Unmapped: zero data, error answer
        next_rresp = RESP_SLVERR;
      end
    end
  end

  // Read path registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // First controller: all four functions
  // parity fault kept in async only
  // framing fault kept in async only
  // DMA unloads in async and sync
  scmi_event_gate #(
    .HAS_ASYNC (1'b1)
  ) u_gate_one (
    .mode   (mode_one),
    .evt_in (evt_one),
    .lvl_in (lvl_one),
    .gated  (gated_one)
  );

  // Second controller: no asynchronous mode
  // no-ack kept in two-wire only
  scmi_event_gate #(
    .HAS_ASYNC (1'b0)
  ) u_gate_two (
    .mode   (mode_two),
    .evt_in (evt_two),
    .lvl_in (lvl_two),
    .gated  (gated_two)
  );

  // Flags and irq, first controller
  // underrun and overrun in every mode except off
  scmi_flag_bank u_bank_one (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .gated      (gated_one),
    .trig_style (trig_one),
    .enable     (enable_one),
    .clear      (clear_one),
    .pending    (pending_one),
    .irq        (irq_one)
  );

  // Flags and irq, second controller
  // enabled pending raises irq
  scmi_flag_bank u_bank_two (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .gated      (gated_two),
    .trig_style (trig_two),
    .enable     (enable_two),
    .clear      (clear_two),
    .pending    (pending_two),
    .irq        (irq_two)
  );

endmodule

`default_nettype wire

//--- dv/scmi_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module scmi_top_assertions (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 awvalid,
  input wire logic                 awready,
  input wire logic                 wvalid,
  input wire logic                 wready,
  input wire logic [1:0]           bresp,
  input wire logic                 bvalid,
  input wire logic                 bready,
  input wire logic                 arvalid,
  input wire logic                 arready,
  input wire logic [31:0]          rdata,
  input wire logic                 rvalid,
  input wire logic                 rready,
  input wire scmi_pkg::scmi_mode_t mode_one,
  input wire scmi_pkg::scmi_mode_t mode_two,
  input wire logic                 irq_one
);
  import scmi_pkg::*;

  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Read answers exactly one cycle after the take
  rd_latency_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer not one cycle after address take");
  // Read answer stands while master stalls
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped or changed before rready");
  // Read slot frees once the answer is taken
  rd_done_a: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not released after handshake");
  // Write performs and answers on the same edge, one edge after both halves
  wr_latency_a: assert property (awvalid && awready && wvalid && wready && !bvalid
                                 |=> !awready && !wready && !bvalid ##1 bvalid)
    else $error("write response timing wrong");
  // Write response stands while master stalls
  wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped or changed before bready");
  mode_two_async_a: assert property (mode_two != MODE_ASYNC)
    else $error("second controller entered asynchronous mode");
  mode_by_write_a: assert property (
    !$stable(mode_one) || !$stable(mode_two) |-> $rose(bvalid))
    else $error("mode field moved without a register write");
  irq_fall_cause_a: assert property ($fell(irq_one) |-> $past(bvalid))
    else $error("interrupt fell without a clearing or masking write");

  // Main scenarios reached
  irq_seen_c: cover property ($rose(irq_one));
  slverr_seen_c: cover property (bvalid && bresp == RESP_SLVERR);
  twowire_seen_c: cover property (mode_one == MODE_TWOWIRE);
endmodule

`default_nettype wire

//--- dv/scmi_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module scmi_top_tb;
  import scmi_pkg::*;

  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
  logic        awready, wready, bvalid, arready, rvalid, irq_one, irq_two;
  logic [31:0] awaddr, wdata, araddr, rdata, got;
  logic [14:0] exp_f;          // Expected flags after one pulse
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  scmi_evt_t   evt_one, evt_two;
  scmi_lvl_t   lvl_one, lvl_two;
  scmi_mode_t  mode_one, mode_two;
  int          err_total, checks_done, eff;
  int          cycles = 0;     // Driven by the hang guard alone
  // Sources each mode lets through: off, async, sync, two-wire
  logic [14:0] allow [4] = '{15'h0000, 15'h7e1f, 15'h1e1f, 15'h01ff};
  // Pend1, pend2, en1, en2, trig1, trig2, mode2, mode1
  logic [31:0] regs [8] = '{OFS_CTRL1_IRQ_PENDING, OFS_CTRL2_IRQ_PENDING,
    OFS_CTRL1_IRQ_ENABLE, OFS_CTRL2_IRQ_ENABLE, OFS_CTRL1_TRIG_STYLE,
    OFS_CTRL2_TRIG_STYLE, OFS_CTRL2_MODE_SELECT, OFS_CTRL1_MODE_SELECT};

  scmi_top dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .evt_one(evt_one),
    .lvl_one(lvl_one), .evt_two(evt_two), .lvl_two(lvl_two),
    .mode_one(mode_one), .mode_two(mode_two), .irq_one(irq_one), .irq_two(irq_two));

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic end_sim;
    $display("Checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, far above the expected run length
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      $display("MISMATCH timeout expected done seen hang");
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow;
    forever begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!dd && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // A slow master leaves rready low for the first answer cycle
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    if (slow) begin
      rready <= 1'b1;
      @(posedge aclk);
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wreg(input logic [31:0] a, input logic [31:0] d);
    wr(a, d, resp);
    chk($sformatf("bresp %h", a), {30'h0, RESP_OKAY}, {30'h0, resp});
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    rd(a, got, resp);
    chk($sformatf("reg %h", a), e, got);
    chk($sformatf("rresp %h", a), {30'h0, RESP_OKAY}, {30'h0, resp});
  endtask

  // One-cycle event pulse on one controller
  task automatic pulse(input int c, input logic [11:0] v);
    if (c == 0) evt_one <= v;
    else evt_two <= v;
    @(posedge aclk);
    evt_one <= '0;
    evt_two <= '0;
    @(posedge aclk);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, wstrb} = '0;
    {evt_one, evt_two, lvl_one, lvl_two} = '0;
    {err_total, checks_done} = '0;
    slow = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Everything clear out of reset
    for (int i = 0; i < 8; i++) rchk(regs[i], 32'h0);
    // Unmapped place answers with an error and no data
    rd(32'h4000a900, got, resp);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    chk("unmapped rdata", 32'h0, got);
    wr(32'h4000a900, 32'hffffffff, resp);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    // Enable and trigger style widths
    wreg(regs[2], 32'hffffffff);
    rchk(regs[2], 32'h00007fff);
    wreg(regs[3], 32'hffffffff);
    rchk(regs[3], 32'h00001fff);
    wreg(regs[4], 32'hffffffff);
    rchk(regs[4], 32'h00000007);
    for (int i = 2; i < 5; i++) wreg(regs[i], 32'h0);
    slow = 1'b0;
    // Every event source in every mode, both controllers
    for (int c = 0; c < 2; c++) begin
      for (int m = 0; m < 4; m++) begin
        wreg(regs[7 - c], 32'(m));
        eff = (c == 1 && m == 1) ? 0 : m;
        rchk(regs[7 - c], 32'(eff));
        chk("mode port", 32'(eff), {30'h0, c ? mode_two : mode_one});
        for (int b = 3; b < 15; b++) begin
          pulse(c, 12'h001 << (b - 3));
          wreg(regs[c], 32'h0);
          exp_f = allow[eff] & (c ? 15'h1fff : 15'h7fff) & (15'h1 << b);
          rchk(regs[c], {17'h0, exp_f});
          wreg(regs[c], 32'h1 << b);
          rchk(regs[c], 32'h0);
        end
      end
    end
    // Status levels, edge then level style, controller one
    for (int b = 0; b < 3; b++) begin
      lvl_one <= 3'h1 << b;
      repeat (2) @(posedge aclk);
      rchk(regs[0], 32'h1 << b);
      wreg(regs[0], 32'h1 << b);
      rchk(regs[0], 32'h0);
      wreg(regs[4], 32'h1 << b);
      wreg(regs[0], 32'h1 << b);
      rchk(regs[0], 32'h1 << b);
      lvl_one <= '0;
      wreg(regs[4], 32'h0);
      wreg(regs[0], 32'h7);
      rchk(regs[0], 32'h0);
    end
    // Interrupt raise, mask, unmask, clear
    // Setup order: function off, style, sources, function last
    wreg(regs[7], 32'h0);
    wreg(regs[4], 32'h0);
    wreg(regs[2], 32'h100);
    wreg(regs[7], 32'h3);
    pulse(0, 12'h020);
    #1;
    chk("irq one raised", 32'h1, {31'h0, irq_one});
    @(posedge aclk);
    wreg(regs[2], 32'h0);
    chk("irq one masked", 32'h0, {31'h0, irq_one});
    wreg(regs[2], 32'h100);
    chk("irq one unmasked", 32'h1, {31'h0, irq_one});
    wreg(regs[0], 32'h100);
    chk("irq one cleared", 32'h0, {31'h0, irq_one});
    chk("irq two quiet", 32'h0, {31'h0, irq_two});
    wreg(regs[5], 32'h0);
    wreg(regs[3], 32'h8);
    pulse(1, 12'h001);
    #1;
    chk("irq two raised", 32'h1, {31'h0, irq_two});
    @(posedge aclk);
    wreg(regs[1], 32'h8);
    chk("irq two cleared", 32'h0, {31'h0, irq_two});
    end_sim();
  end
endmodule

bind scmi_top scmi_top_assertions chk_u (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .mode_one(mode_one), .mode_two(mode_two),
  .irq_one(irq_one));

`default_nettype wire
